// ---- core/iors_pkg.sv ----
// Constants shared by the I/O refresh sequencer and its bench.
// Assumes a 32-bit APB register bus and 16-bit word addressing of the
// core I/O and data memory areas.
package iors_pkg;

   // ==========================================================
   // Register map (byte addresses on APB)
   // ==========================================================
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_CMD = 12'h000;
   localparam logic [11:0] OFS_ARG0 = 12'h004;
   localparam logic [11:0] OFS_ARG1 = 12'h008;
   localparam logic [11:0] OFS_STATE = 12'h00C;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h010;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h014;
   // Setup words holding the cyclic-refresh disable bits, kept as indices.
   localparam logic [9:0] IDX_DISABLE_FIRST = 10'd226;
   localparam logic [9:0] IDX_DISABLE_LAST = 10'd231;

   // ==========================================================
   // Command register fields
   // ==========================================================
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_FROM_INT = 3;
   localparam int CMD_OUTPUT = 4;
   localparam int CMD_BIT_ADDR = 5;
   localparam logic [2:0] OP_OPERAND = 3'h1;
   localparam logic [2:0] OP_RANGE = 3'h2;
   localparam logic [2:0] OP_SPECIAL = 3'h3;
   localparam logic [2:0] OP_BUS = 3'h4;
   localparam logic [2:0] OP_UNIT_READ = 3'h5;
   localparam logic [2:0] OP_UNIT_WRITE = 3'h6;

   // ==========================================================
   // Status and interrupt bits
   // ==========================================================
   localparam int ST_BUSY = 0;
   localparam int ST_EQUALS = 1;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_SPECIAL_ERR = 1;
   localparam int IRQ_INT_TASK_ERR = 2;
   localparam int IRQ_CMD_ERR = 3;
   localparam int IRQ_BUS_SKIP = 4;
   localparam int IRQ_W = 5;

   // ==========================================================
   // Area layout (word addresses)
   // ==========================================================
   localparam logic [15:0] BASIC_BASE = 16'h0000;
   localparam logic [15:0] BASIC_WORDS = 16'h0050;
   localparam logic [15:0] SPECIAL_BASE = 16'd2000;
   localparam logic [15:0] SPECIAL_LAST = 16'd2959;
   localparam logic [15:0] SP_CORE_WORDS = 16'd10;
   localparam logic [15:0] SP_DM_BASE = 16'h4E20;
   localparam logic [15:0] SP_DM_WORDS = 16'h0008;
   localparam int NUM_SPECIAL = 96;
   localparam logic [6:0] SPECIAL_UNIT_LAST = 7'd95;
   localparam logic [15:0] BUS_CORE_BASE = 16'd1500;
   localparam logic [15:0] BUS_CORE_WORDS = 16'd25;
   localparam logic [15:0] BUS_DM_BASE = 16'h7530;
   localparam logic [15:0] BUS_DM_WORDS = 16'h0008;
   localparam logic [15:0] BUS_LINK_WORDS = 16'h0008;
   localparam int NUM_BUS = 16;
   localparam logic [6:0] BUS_UNIT_LAST = 7'd15;

   // ==========================================================
   // Transfer port encodings
   // ==========================================================
   localparam logic [1:0] SPACE_CORE = 2'h0;
   localparam logic [1:0] SPACE_DM = 2'h1;
   localparam logic [1:0] SPACE_LINK = 2'h2;
   localparam logic [1:0] DIR_EXCHANGE = 2'h0;
   localparam logic [1:0] DIR_IN = 2'h1;
   localparam logic [1:0] DIR_OUT = 2'h2;

endpackage : iors_pkg

// ---- core/iors_io_refresh_sequencer.sv ----
// I/O refresh sequencer: cyclic and immediate refresh of basic, special
// and bus-attached units, controlled over APB.
// Assumes the unit side acknowledges one word per xfer_ack pulse and that
// the CPU pulses program_done and instr_exec_done synchronously to pclk.

// Behaviour
// - Cyclic refresh starts only after program_done marks the scan finished.
// - Operand refresh accepts only basic-unit words; other targets are refused.
// - Word operand inputs refresh their whole 16-bit word before execution.
// - Bit operands refresh the holding word; outputs wait for execution end.
// - Range refresh transfers every word from start through end inclusive.
// - Range refresh stays inside the core area up to word 2959, so it can cover bus-unit core words from 1500.
// - Special-unit refresh moves its core words and data memory words.
// - Bus-unit refresh moves core words, data memory words and link data.
// - Bus-unit refresh of a busy unit is skipped; only an immediate refresh also clears the equals flag.
// - Each special unit owns ten core words from word 2000 up to 2959.
// - Ninety-six disable bits in setup words 226 to 231, reset to zero.
// - Disabled special units are left out of cyclic refresh only.
// - Refreshing a special unit still busy sets the special unit error.
// - Interrupt-task access to a cyclically refreshed special unit is an error.
// - Range refresh time grows one transfer per word.
module iors_io_refresh_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [iors_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic program_done,
   input wire logic instr_exec_done,
   input wire logic [iors_pkg::NUM_SPECIAL-1:0] special_unit_busy,
   input wire logic [iors_pkg::NUM_BUS-1:0] bus_unit_busy,
   output logic xfer_req,
   output logic [1:0] xfer_space,
   output logic [1:0] xfer_dir,
   output logic [15:0] xfer_addr,
   input wire logic xfer_ack,
   output logic refresh_busy,
   output logic equals_flag,
   output logic cyclic_done,
   output logic irq
);
   import iors_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_EXEC, ST_SEG, ST_XFER, ST_NEXT
   } iors_state_e;
   typedef enum logic [1:0] {
      PH_BASIC, PH_SPECIAL, PH_BUS, PH_SINGLE
   } iors_phase_e;

   // ==========================================================
   // Registers
   // ==========================================================
   iors_state_e state_reg;
   iors_phase_e phase_reg;
   logic [6:0] unit_reg;
   logic [1:0] seg_reg;
   logic [15:0] left_reg;
   logic cyclic_reg;
   logic cyclic_pend_reg;
   logic [15:0] single_base_reg;
   logic [15:0] single_cnt_reg;
   logic [5:0] cmd_reg;
   logic [19:0] arg0_reg;
   logic [15:0] arg1_reg;
   logic [NUM_SPECIAL-1:0] dis_bits_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_set;

   // ==========================================================
   // APB decode
   // ==========================================================
   wire acc = psel & penable;
   wire wr_fire = acc & pwrite & pready;
   wire [9:0] widx = paddr[11:2];
   wire hit_cmd = (paddr == OFS_CMD);
   wire hit_arg0 = (paddr == OFS_ARG0);
   wire hit_arg1 = (paddr == OFS_ARG1);
   wire hit_state = (paddr == OFS_STATE);
   wire hit_istat = (paddr == OFS_IRQ_STAT);
   wire hit_imask = (paddr == OFS_IRQ_MASK);
   wire hit_dis = (paddr[1:0] == 2'h0) && (widx >= IDX_DISABLE_FIRST) &&
      (widx <= IDX_DISABLE_LAST);
   wire [2:0] dis_sel = 3'(widx - IDX_DISABLE_FIRST);
   wire hit_any = hit_cmd | hit_arg0 | hit_arg1 | hit_state | hit_istat |
      hit_imask | hit_dis;
   wire [31:0] dis_word = {16'h0000, dis_bits_reg[dis_sel*16 +: 16]};
   wire [31:0] state_word = {30'h0, equals_flag, refresh_busy};
   wire [31:0] rdata;
   assign rdata = hit_cmd ? {26'h0, cmd_reg} :
      hit_arg0 ? {12'h000, arg0_reg} :
      hit_arg1 ? {16'h0000, arg1_reg} :
      hit_state ? state_word :
      hit_istat ? {27'h0, irq_stat_reg} :
      hit_imask ? {27'h0, irq_mask_reg} :
      hit_dis ? dis_word : 32'h0000_0000;

   // ==========================================================
   // Command decode
   // ==========================================================
   wire cmd_fire = wr_fire & hit_cmd;
   wire [2:0] new_op = pwdata[CMD_OP_LSB +: 3];
   wire new_int = pwdata[CMD_FROM_INT];
   wire new_out = pwdata[CMD_OUTPUT];
   wire new_bit = pwdata[CMD_BIT_ADDR];
   wire idle = (state_reg == ST_IDLE);
   // A bit address names the word that holds it.
   wire [15:0] op_word = new_bit ? arg0_reg[19:4] : arg0_reg[15:0];
   wire op_basic = (op_word < BASIC_WORDS);
   wire [15:0] rng_start = arg0_reg[15:0];
   wire [15:0] rng_end = arg1_reg;
   wire rng_ok = (rng_start <= rng_end) && (rng_end <= SPECIAL_LAST);
   wire [15:0] rng_cnt = 16'(rng_end - rng_start + 16'h0001);
   wire [6:0] cmd_unit = arg0_reg[6:0];
   wire sp_unit_ok = (cmd_unit <= SPECIAL_UNIT_LAST);
   wire bus_unit_ok = (cmd_unit <= BUS_UNIT_LAST);
   wire sp_enabled = sp_unit_ok && !dis_bits_reg[cmd_unit];
   logic [NUM_SPECIAL-1:0] rng_live;

   // Special units in the range that are still cyclically refreshed.
   genvar gu;
   generate
      for (gu = 0; gu < NUM_SPECIAL; gu++) begin : g_ovl
         localparam logic [15:0] LO = 16'(SPECIAL_BASE + gu * SP_CORE_WORDS);
         localparam logic [15:0] HI = 16'(LO + SP_CORE_WORDS - 16'h0001);
         assign rng_live[gu] = (rng_start <= HI) && (rng_end >= LO) &&
            !dis_bits_reg[gu];
      end
   endgenerate

   wire is_unit_op = (new_op == OP_SPECIAL) || (new_op == OP_UNIT_READ) ||
      (new_op == OP_UNIT_WRITE);
   wire int_err = new_int && (((new_op == OP_RANGE) && (|rng_live)) ||
      (is_unit_op && sp_enabled));
   wire bad_cmd = !idle ||
      ((new_op == OP_OPERAND) && !op_basic) ||
      ((new_op == OP_RANGE) && !rng_ok) ||
      (is_unit_op && !sp_unit_ok) ||
      ((new_op == OP_BUS) && !bus_unit_ok) ||
      (new_op == 3'h0) || (new_op == 3'h7);
   wire bus_skip = (new_op == OP_BUS) && bus_unit_busy[cmd_unit[3:0]];
   wire cmd_go = cmd_fire && !bad_cmd && !int_err && !bus_skip;

   // ==========================================================
   // Segment table
   // ==========================================================
   wire [15:0] unit16 = {9'h000, unit_reg};
   wire [15:0] sp_core = 16'(SPECIAL_BASE + unit16 * SP_CORE_WORDS);
   wire [15:0] sp_dm = 16'(SP_DM_BASE + unit16 * SP_DM_WORDS);
   wire [15:0] bus_core = 16'(BUS_CORE_BASE + unit16 * BUS_CORE_WORDS);
   wire [15:0] bus_dm = 16'(BUS_DM_BASE + unit16 * BUS_DM_WORDS);
   logic [1:0] seg_space;
   logic [15:0] seg_base;
   logic [15:0] seg_cnt;
   logic seg_last;
   logic [1:0] unit_dir_reg;

   always_comb begin
      seg_space = SPACE_CORE;
      seg_base = single_base_reg;
      seg_cnt = single_cnt_reg;
      seg_last = 1'b1;
      case (phase_reg)
         PH_BASIC: begin
            seg_base = BASIC_BASE;
            seg_cnt = BASIC_WORDS;
         end
         PH_SPECIAL: begin
            // Core words first, then the data memory block.
            seg_last = (seg_reg == 2'h1);
            if (seg_reg == 2'h0) begin
               seg_base = sp_core;
               seg_cnt = SP_CORE_WORDS;
            end else begin
               seg_space = SPACE_DM;
               seg_base = sp_dm;
               seg_cnt = SP_DM_WORDS;
            end
         end
         PH_BUS: begin
            seg_last = (seg_reg == 2'h2);
            if (seg_reg == 2'h0) begin
               seg_base = bus_core;
               seg_cnt = BUS_CORE_WORDS;
            end else if (seg_reg == 2'h1) begin
               seg_space = SPACE_DM;
               seg_base = bus_dm;
               seg_cnt = BUS_DM_WORDS;
            end else begin
               seg_space = SPACE_LINK;
               seg_base = 16'h0000;
               seg_cnt = BUS_LINK_WORDS;
            end
         end
         default: begin
            seg_last = 1'b1;
         end
      endcase
   end

   wire skip_unit = cyclic_reg && (seg_reg == 2'h0) &&
      (((phase_reg == PH_SPECIAL) && dis_bits_reg[unit_reg]) ||
      ((phase_reg == PH_BUS) && bus_unit_busy[unit_reg[3:0]]));
   wire sp_overrun = (phase_reg == PH_SPECIAL) && (seg_reg == 2'h0) &&
      !skip_unit && special_unit_busy[unit_reg];
   wire unit_last = (phase_reg == PH_SPECIAL) ?
      (unit_reg == SPECIAL_UNIT_LAST) : (unit_reg == BUS_UNIT_LAST);
   wire word_done = (state_reg == ST_XFER) && xfer_ack;
   wire job_end = (state_reg == ST_NEXT) && seg_last &&
      (!cyclic_reg || ((phase_reg == PH_BUS) && unit_last));
   wire cyc_start = idle && !cmd_fire && (program_done || cyclic_pend_reg);

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         phase_reg <= PH_BASIC;
         unit_reg <= 7'h00;
         seg_reg <= 2'h0;
         left_reg <= 16'h0000;
         cyclic_reg <= 1'b0;
         single_base_reg <= 16'h0000;
         single_cnt_reg <= 16'h0001;
         unit_dir_reg <= DIR_EXCHANGE;
         xfer_req <= 1'b0;
         xfer_space <= SPACE_CORE;
         xfer_dir <= DIR_EXCHANGE;
         xfer_addr <= 16'h0000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cmd_go) begin
                  cyclic_reg <= 1'b0;
                  unit_reg <= cmd_unit;
                  seg_reg <= 2'h0;
                  if (new_op == OP_OPERAND) begin
                     phase_reg <= PH_SINGLE;
                     single_base_reg <= op_word;
                     single_cnt_reg <= 16'h0001;
                     unit_dir_reg <= new_out ? DIR_OUT : DIR_IN;
                     // Outputs refresh only once the instruction ends.
                     state_reg <= new_out ? ST_WAIT_EXEC : ST_SEG;
                  end else if (new_op == OP_RANGE) begin
                     phase_reg <= PH_SINGLE;
                     single_base_reg <= rng_start;
                     single_cnt_reg <= rng_cnt;
                     unit_dir_reg <= DIR_EXCHANGE;
                     state_reg <= ST_SEG;
                  end else if (new_op == OP_BUS) begin
                     phase_reg <= PH_BUS;
                     unit_dir_reg <= DIR_EXCHANGE;
                     state_reg <= ST_SEG;
                  end else begin
                     phase_reg <= PH_SPECIAL;
                     unit_dir_reg <= (new_op == OP_UNIT_READ) ? DIR_IN :
                        (new_op == OP_UNIT_WRITE) ? DIR_OUT : DIR_EXCHANGE;
                     state_reg <= ST_SEG;
                  end
               end else if (cyc_start) begin
                  cyclic_reg <= 1'b1;
                  phase_reg <= PH_BASIC;
                  unit_reg <= 7'h00;
                  seg_reg <= 2'h0;
                  unit_dir_reg <= DIR_EXCHANGE;
                  state_reg <= ST_SEG;
               end
            end
            ST_WAIT_EXEC: begin
               if (instr_exec_done) begin
                  state_reg <= ST_SEG;
               end
            end
            ST_SEG: begin
               if (skip_unit) begin
                  seg_reg <= (phase_reg == PH_BUS) ? 2'h2 : 2'h1;
                  state_reg <= ST_NEXT;
               end else begin
                  left_reg <= seg_cnt;
                  xfer_addr <= seg_base;
                  xfer_space <= seg_space;
                  xfer_dir <= unit_dir_reg;
                  xfer_req <= 1'b1;
                  state_reg <= ST_XFER;
               end
            end
            ST_XFER: begin
               // One word per acknowledge, so time scales with length.
               if (xfer_ack) begin
                  if (left_reg > 16'h0001) begin
                     left_reg <= 16'(left_reg - 16'h0001);
                     xfer_addr <= 16'(xfer_addr + 16'h0001);
                  end else begin
                     xfer_req <= 1'b0;
                     state_reg <= ST_NEXT;
                  end
               end
            end
            ST_NEXT: begin
               if (!seg_last) begin
                  seg_reg <= 2'(seg_reg + 2'h1);
                  state_reg <= ST_SEG;
               end else if (job_end) begin
                  state_reg <= ST_IDLE;
               end else begin
                  seg_reg <= 2'h0;
                  state_reg <= ST_SEG;
                  if (phase_reg == PH_BASIC) begin
                     phase_reg <= PH_SPECIAL;
                     unit_reg <= 7'h00;
                  end else if (unit_last) begin
                     phase_reg <= PH_BUS;
                     unit_reg <= 7'h00;
                  end else begin
                     unit_reg <= 7'(unit_reg + 7'h01);
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Status, flags and interrupt
   // ==========================================================
   assign irq_set[IRQ_DONE] = job_end;
   assign irq_set[IRQ_SPECIAL_ERR] = (state_reg == ST_SEG) && sp_overrun;
   assign irq_set[IRQ_INT_TASK_ERR] = cmd_fire && int_err && !bad_cmd;
   assign irq_set[IRQ_CMD_ERR] = cmd_fire && bad_cmd;
   assign irq_set[IRQ_BUS_SKIP] = cmd_fire && !bad_cmd && !int_err &&
      bus_skip;
   wire [IRQ_W-1:0] irq_clr = (wr_fire && hit_istat) ? pwdata[IRQ_W-1:0] :
      {IRQ_W{1'b0}};
   // New events win over a clear in the same cycle.
   wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= {IRQ_W{1'b0}};
         irq <= 1'b0;
         refresh_busy <= 1'b0;
         cyclic_done <= 1'b0;
         cyclic_pend_reg <= 1'b0;
         equals_flag <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_mask_reg);
         refresh_busy <= !((state_reg == ST_IDLE) && !cmd_go && !cyc_start)
            && !job_end;
         cyclic_done <= job_end && cyclic_reg;
         // A scan end seen while busy is kept until the sequencer frees.
         if (program_done && !cyc_start) begin
            cyclic_pend_reg <= 1'b1;
         end else if (cyc_start) begin
            cyclic_pend_reg <= 1'b0;
         end
         if (irq_set[IRQ_BUS_SKIP]) begin
            equals_flag <= 1'b0;
         end else if (job_end && (phase_reg == PH_BUS) && !cyclic_reg) begin
            equals_flag <= 1'b1;
         end
      end
   end

   // ==========================================================
   // APB registers and answer
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         cmd_reg <= 6'h00;
         arg0_reg <= 20'h00000;
         arg1_reg <= 16'h0000;
         irq_mask_reg <= {IRQ_W{1'b0}};
         dis_bits_reg <= {NUM_SPECIAL{1'b0}};
      end else begin
         // One wait state: the answer is ready on the second access cycle.
         pready <= acc && !pready;
         pslverr <= acc && !pready && !hit_any;
         prdata <= (acc && !pready && !pwrite) ? rdata : 32'h0000_0000;
         if (cmd_fire) begin
            cmd_reg <= pwdata[5:0];
         end
         if (wr_fire && hit_arg0) begin
            arg0_reg <= pwdata[19:0];
         end
         if (wr_fire && hit_arg1) begin
            arg1_reg <= pwdata[15:0];
         end
         if (wr_fire && hit_imask) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
         end
         if (wr_fire && hit_dis) begin
            dis_bits_reg[dis_sel*16 +: 16] <= pwdata[15:0];
         end
      end
   end

endmodule : iors_io_refresh_sequencer

// ---- test/iors_properties.sv ----
// Port assertions for the I/O refresh sequencer.
// Assumes binding to the sequencer top; one clock, reset active low.
module iors_checker import iors_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic program_done,
   input wire logic refresh_busy,
   input wire logic xfer_req,
   input wire logic xfer_ack,
   input wire logic [1:0] xfer_space,
   input wire logic [15:0] xfer_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      !pready ##1 pready;
   endsequence
   a_one_wait: assert property (s_setup |=> s_answer)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside answer");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   a_req_busy: assert property (xfer_req |-> refresh_busy)
      else $error("transfer without busy");
   a_addr_hold: assert property (xfer_req && !xfer_ack |=>
      xfer_req && $stable(xfer_addr)) else $error("word dropped");
   a_addr_step: assert property (xfer_req && xfer_ack |=> !xfer_req ||
      xfer_addr == $past(xfer_addr) + 16'h1 || xfer_space != $past(xfer_space))
      else $error("address skipped");
   a_core_bound: assert property (xfer_req && xfer_space == SPACE_CORE
      |-> xfer_addr <= SPECIAL_LAST) else $error("core word out of area");
   a_scan_start: assert property (program_done && !refresh_busy
      |-> ##[1:3] refresh_busy) else $error("cyclic refresh not started");
endmodule : iors_checker

// ---- test/iors_unit_model.sv ----
// Unit-side model: acknowledges each requested word after a set lag.
// Assumes the sequencer holds xfer_req and xfer_addr until acknowledged.
module iors_unit_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic xfer_req,
   input wire logic [1:0] lag,
   output logic xfer_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   // The acknowledge drops for a cycle after each word so no stale pulse
   // can complete the next word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 2'h0;
         xfer_ack <= 1'b0;
      end else begin
         xfer_ack <= xfer_req && !xfer_ack && wait_cnt >= lag;
         wait_cnt <= (xfer_req && !xfer_ack && wait_cnt < lag) ?
            wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule : iors_unit_model

// ---- test/test_io_refresh_sequencer.sv ----
// Self-checking bench for the sequencer, driven over APB.
// Assumes the unit model answers every transfer.
module test_io_refresh_sequencer import iors_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic program_done = 0, instr_exec_done = 0, pready, pslverr, ev;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   logic [95:0] sp_busy = 0;
   logic [15:0] bu_busy = 0, xfer_addr, last_addr;
   logic xfer_req, xfer_ack, refresh_busy, equals_flag, cyclic_done, irq;
   logic [1:0] xfer_space, xfer_dir, lag = 0;
   int miscompares = 0, n_compared = 0, n_words = 0, n_win = 0, base, wbase;
   iors_io_refresh_sequencer dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .program_done,
      .instr_exec_done, .special_unit_busy(sp_busy), .bus_unit_busy(bu_busy),
      .xfer_req, .xfer_space, .xfer_dir, .xfer_addr, .xfer_ack, .refresh_busy,
      .equals_flag, .cyclic_done, .irq);
   iors_unit_model model_u (.pclk, .presetn, .xfer_req, .lag, .xfer_ack);
   initial forever #5 pclk = ~pclk;
   // Window counts core words of special units 0 and 1.
   always @(posedge pclk) if (xfer_req && xfer_ack) begin
      n_words++;
      last_addr = xfer_addr;
      if (xfer_space == SPACE_CORE && xfer_addr >= SPECIAL_BASE &&
         xfer_addr < SPECIAL_BASE + 16'h14) n_win++;
   end
   task finish_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask : chk
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin miscompares++; finish_test(); end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : bus
   task rdm(string nm, logic [11:0] a, logic [31:0] m, logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rv & m);
   endtask : rdm
   task wait_idle();
      int k;
      repeat (2) @(posedge pclk);
      for (k = 0; refresh_busy !== 1'b0 && k < 20000; k++) @(posedge pclk);
      if (k >= 20000) begin miscompares++; finish_test(); end
   endtask : wait_idle
   task job(logic [31:0] cmd, logic [31:0] a0, logic [31:0] a1);
      bus(1'b1, OFS_IRQ_STAT, 32'h1F);
      bus(1'b1, OFS_ARG0, a0);
      bus(1'b1, OFS_ARG1, a1);
      base = n_words; wbase = n_win;
      bus(1'b1, OFS_CMD, cmd);
      wait_idle();
   endtask : job
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // ==========================================================
      // Registers and interrupt
      // ==========================================================
      rdm("state", OFS_STATE, 32'hFFFFFFFF, 32'h0);
      rdm("disable first", 12'h388, 32'hFFFF, 32'h0);
      rdm("disable last", 12'h39C, 32'hFFFF, 32'h0);
      bus(1'b0, 12'h0FC, 32'h0);
      chk("unmapped", 32'h1, {31'h0, ev});
      job({29'h0, OP_RANGE}, 32'hA, 32'hB);
      chk("range words", 32'h2, n_words - base);
      chk("range end", 32'hB, {16'h0, last_addr});
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      @(posedge pclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      bus(1'b1, OFS_IRQ_MASK, 32'h0);
      $display("register test done");
      job({29'h0, OP_OPERAND}, 32'h50, 32'h0);
      rdm("operand refused", OFS_IRQ_STAT, 32'h8, 32'h8);
      chk("irq masked", 32'h0, {31'h0, irq});
      job({29'h0, OP_OPERAND}, 32'h5, 32'h0);
      chk("word operand", 32'h1, n_words - base);
      bus(1'b1, OFS_ARG0, 32'h53);
      base = n_words;
      bus(1'b1, OFS_CMD, 32'h31);
      repeat (5) @(posedge pclk);
      chk("output held", 32'h0, n_words - base);
      instr_exec_done <= 1'b1;
      @(posedge pclk);
      instr_exec_done <= 1'b0;
      wait_idle();
      chk("output word", 32'h5, {16'h0, last_addr});
      chk("output dir", DIR_OUT, xfer_dir);
      $display("operand test done");
      lag <= 2'h2;
      sp_busy[1] <= 1'b1;
      job({29'h0, OP_SPECIAL}, 32'h1, 32'h0);
      chk("special words", 32'd18, n_words - base);
      chk("special core", 32'd10, n_win - wbase);
      chk("special dm end", 32'h4E2F, {16'h0, last_addr});
      rdm("special error", OFS_IRQ_STAT, 32'h2, 32'h2);
      sp_busy <= '0;
      lag <= 2'h0;
      job({29'h0, OP_BUS}, 32'h1, 32'h0);
      chk("bus words", 32'd41, n_words - base);
      rdm("equals set", OFS_STATE, 32'h2, 32'h2);
      bu_busy[1] <= 1'b1;
      job({29'h0, OP_BUS}, 32'h1, 32'h0);
      chk("bus skipped", 32'h0, n_words - base);
      rdm("equals clear", OFS_STATE, 32'h2, 32'h0);
      rdm("skip irq", OFS_IRQ_STAT, 32'h10, 32'h10);
      bu_busy <= '0;
      $display("unit test done");
      for (int i = 5; i < 7; i++) begin
         job(32'h8 | i, 32'h1, 32'h0);
         rdm("int unit op", OFS_IRQ_STAT, 32'h4, 32'h4);
      end
      job(32'hA, 32'd2000, 32'd2009);
      chk("int range refused", 32'h0, n_words - base);
      bus(1'b1, 12'h388, 32'h1);
      rdm("disable set", 12'h388, 32'hFFFF, 32'h1);
      job(32'hA, 32'd2000, 32'd2009);
      chk("int range run", 32'd10, n_words - base);
      wbase = n_win;
      program_done <= 1'b1;
      @(posedge pclk);
      program_done <= 1'b0;
      wait_idle();
      chk("cyclic skips", 32'd10, n_win - wbase);
      chk("cyclic done", 1, cyclic_done);
      $display("cyclic test done");
      finish_test();
   end
endmodule : test_io_refresh_sequencer

bind iors_io_refresh_sequencer iors_checker chk_u (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .prdata, .program_done, .refresh_busy,
   .xfer_req, .xfer_ack, .xfer_space, .xfer_addr);
